// ---- led_serial_map.svh ----
// offsets, field positions, reset values and timing counts for the serial load port
// assumes a 125 MHz core clock
`ifndef LED_SERIAL_MAP_SVH
`define LED_SERIAL_MAP_SVH
`define DOT_BITS          160
`define CTRL_BITS         8
`define CWORD_BITS        7
`define CTRL_SEL_BIT      7
`define CW0_SLEEP_BIT     6
`define CW1_SIMUL_BIT     0
`define CW1_PRESCALE_BIT  1
`define CWORD_RESET       7'h00
`define CORE_CLK_MHZ      125
`define INT_OSC_KHZ       125
`define INT_OSC_HALF      ((`CORE_CLK_MHZ * 1000) / (2 * `INT_OSC_KHZ))
`define PRESCALE_SLOW     8
`endif

// ---- led_serial_pkg.sv ----
// types shared by the serial load port
// assumes led_serial_map.svh is compiled first
package led_serial_pkg;
    typedef struct packed {
        logic data;
        logic shift_clk;
        logic chip_en_n;
        logic target_choice;
    } serial_in_t;
    typedef enum logic {
        tgt_dot,
        tgt_ctrl
    } target_t;
endpackage : led_serial_pkg

// ---- led_matrix_serial_load_port.sv ----
// serial load port, dot register, control words and refresh clock choice
// assumes serial pins are already synchronous to core_clk; edges found by sampling
// Functional notes
// - reset clears every control word bit
// - reset leaves dot register untouched
// - reset input active low
// - rising shift clock shifts serial input
// - shifting only while chip enable low
// - serial output feeds chained displays
// - select low dot, high control
// - select captured at chip enable fall
// - enable high, clock low copies data
// - oscillator select high internal, low external
// - oscillator pin drives out when internal
// - dark input high blanks all leds
// - external oscillator prescale one or eight
// - dot shift register holds 160 bits
// - control load eight bits, msb selects word
// - reset puts display to sleep
`include "led_serial_map.svh"
module led_matrix_serial_load_port (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire led_serial_pkg::serial_in_t ser_in,
    input  wire logic                      osc_select,
    input  wire logic                      osc_pin_in,
    input  wire logic                      dark_display_input,
    output logic                           ser_out,
    output logic                           osc_pin_out,
    output logic                           osc_pin_oe,
    output logic                           refresh_tick,
    output logic [`DOT_BITS-1:0]           led_drive,
    output logic [`CWORD_BITS-1:0]         cword0,
    output logic [`CWORD_BITS-1:0]         cword1
);
    logic                   clk_d_r;
    logic                   ce_n_d_r;
    logic                   osc_in_d_r;
    led_serial_pkg::target_t target_r;
    logic [`DOT_BITS-1:0]   dot_shift_r;
    logic [`DOT_BITS-1:0]   dot_latch_r;
    logic [`CTRL_BITS-1:0]  ctrl_shift_r;
    logic                   pending_r;
    logic [15:0]            osc_cnt_r;
    logic                   int_osc_r;
    logic [2:0]             pre_cnt_r;
    logic                   shift_rise;
    logic                   copy_now;
    logic                   src_edge;
    logic                   asleep;

    assign shift_rise = ser_in.shift_clk && !clk_d_r && !ser_in.chip_en_n;
    assign copy_now   = pending_r && ser_in.chip_en_n && !ser_in.shift_clk;
    assign asleep     = !cword0[`CW0_SLEEP_BIT];

    always_ff @(posedge core_clk) begin
        clk_d_r    <= ser_in.shift_clk;
        ce_n_d_r   <= ser_in.chip_en_n;
        osc_in_d_r <= osc_pin_in;
    end

    // select is taken on the chip enable fall only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            target_r <= led_serial_pkg::tgt_dot;
        end else if (ce_n_d_r && !ser_in.chip_en_n) begin
            target_r <= ser_in.target_choice ? led_serial_pkg::tgt_ctrl
                                             : led_serial_pkg::tgt_dot;
        end
    end

    // dot data is never reset, so no reset branch here
    always_ff @(posedge core_clk) begin
        if (shift_rise && target_r == led_serial_pkg::tgt_dot) begin
            dot_shift_r <= {dot_shift_r[`DOT_BITS-2:0], ser_in.data};
        end
        if (copy_now && target_r == led_serial_pkg::tgt_dot) begin
            dot_latch_r <= dot_shift_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_shift_r <= '0;
        end else if (shift_rise && target_r == led_serial_pkg::tgt_ctrl) begin
            ctrl_shift_r <= {ctrl_shift_r[`CTRL_BITS-2:0], ser_in.data};
        end
    end

    // a copy is armed by any shift, so a bare enable pulse copies nothing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (shift_rise) begin
            pending_r <= 1'b1;
        end else if (copy_now) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cword0 <= `CWORD_RESET;
            cword1 <= `CWORD_RESET;
        end else if (copy_now && target_r == led_serial_pkg::tgt_ctrl) begin
            if (ctrl_shift_r[`CTRL_SEL_BIT]) begin
                cword1 <= ctrl_shift_r[`CWORD_BITS-1:0];
            end else begin
                cword0 <= ctrl_shift_r[`CWORD_BITS-1:0];
            end
        end
    end

    // in simultaneous mode the output follows the input one cycle late
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ser_out <= 1'b0;
        end else if (cword1[`CW1_SIMUL_BIT]) begin
            ser_out <= ser_in.data;
        end else if (shift_rise) begin
            ser_out <= (target_r == led_serial_pkg::tgt_dot) ? dot_shift_r[`DOT_BITS-1]
                                                             : ctrl_shift_r[`CTRL_BITS-1];
        end
    end

    // internal oscillator stops in sleep
    always_ff @(posedge core_clk) begin
        if (!rst_n || asleep) begin
            osc_cnt_r <= 16'h0000;
            int_osc_r <= 1'b0;
        end else if (osc_cnt_r == 16'(`INT_OSC_HALF - 1)) begin
            osc_cnt_r <= 16'h0000;
            int_osc_r <= !int_osc_r;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            osc_pin_out <= 1'b0;
            osc_pin_oe  <= 1'b0;
        end else begin
            osc_pin_out <= int_osc_r;
            osc_pin_oe  <= osc_select;
        end
    end

    assign src_edge = osc_select ? (int_osc_r && !osc_pin_out)
                                 : (osc_pin_in && !osc_in_d_r);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pre_cnt_r    <= 3'h0;
            refresh_tick <= 1'b0;
        end else begin
            refresh_tick <= 1'b0;
            if (src_edge) begin
                if (osc_select || !cword1[`CW1_PRESCALE_BIT]) begin
                    refresh_tick <= 1'b1;
                end else if (pre_cnt_r == 3'(`PRESCALE_SLOW - 1)) begin
                    pre_cnt_r    <= 3'h0;
                    refresh_tick <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 3'h1;
                end
            end
        end
    end

    // blanking forces drivers dark but keeps the latch contents
    always_ff @(posedge core_clk) begin
        if (dark_display_input || asleep || !rst_n) begin
            led_drive <= '0;
        end else begin
            led_drive <= dot_latch_r;
        end
    end
endmodule : led_matrix_serial_load_port

// ---- led_port_sva.sv ----
// checker for the serial load port outputs
// assumes bind onto led_matrix_serial_load_port, synchronous reset
`include "led_serial_map.svh"
module led_port_sva (
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    input wire led_serial_pkg::serial_in_t ser_in,
    input wire logic                       osc_select,
    input wire logic                       dark_display_input,
    input wire logic                       ser_out,
    input wire logic                       osc_pin_oe,
    input wire logic                       refresh_tick,
    input wire logic [`DOT_BITS-1:0]       led_drive,
    input wire logic [`CWORD_BITS-1:0]     cword0,
    input wire logic [`CWORD_BITS-1:0]     cword1
);
    default clocking cb @(posedge core_clk); endclocking
    chk_reset_clears_words: assert property (!rst_n |=> cword0 == '0 && cword1 == '0)
        else $error("control words survive reset");
    chk_reset_goes_dark: assert property (!rst_n |=> led_drive == '0)
        else $error("leds lit after reset");
    chk_reset_quiet_outs: assert property (!rst_n |=> !osc_pin_oe && !refresh_tick && !ser_out)
        else $error("outputs active in reset");
    chk_blank_goes_dark: assert property (disable iff (!rst_n) dark_display_input |=> led_drive == '0)
        else $error("leds lit while blanked");
    chk_sleep_goes_dark: assert property (disable iff (!rst_n) !cword0[6] |=> led_drive == '0)
        else $error("leds lit while asleep");
    chk_idle_holds_out: assert property (disable iff (!rst_n) ser_in.chip_en_n && !cword1[0] |=> $stable(ser_out) || cword1[0])
        else $error("serial output moved while disabled");
    chk_words_copy_only: assert property (disable iff (!rst_n) !ser_in.chip_en_n |=> $stable(cword0) && $stable(cword1))
        else $error("control word changed mid transfer");
    chk_osc_pin_dir: assert property (disable iff (!rst_n) $past(rst_n) |-> osc_pin_oe == $past(osc_select))
        else $error("oscillator pin direction wrong");
endmodule : led_port_sva
bind led_matrix_serial_load_port led_port_sva chk (.core_clk, .rst_n, .ser_in, .osc_select,
    .dark_display_input, .ser_out, .osc_pin_oe, .refresh_tick, .led_drive, .cword0, .cword1);

// ---- host_serial_model.sv ----
// host side model driving the serial load pins
// assumes core_clk from the bench; changes pins 1 ns after an edge
module host_serial_model (
    input wire logic                  core_clk,
    output led_serial_pkg::serial_in_t ser_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial ser_in = 4'b0010;
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    // msb first; clock phases of two cycles, copy with clock low
    task automatic send(input logic sel, input int n, input logic [159:0] v);
        ser_in.target_choice = sel;
        ser_in.chip_en_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            step(2);
            ser_in.data = v[i];
            ser_in.shift_clk = 1'b1;
            step(2);
            ser_in.shift_clk = 1'b0;
        end
        step(2);
        ser_in.chip_en_n = 1'b1;
        ser_in.data = ~ser_in.data; // released line: no stale value
        step(2);
    endtask : send
endmodule : host_serial_model

// ---- testbench.sv ----
// self-checking bench for the serial load port
// assumes host_serial_model drives the serial pins
`include "led_serial_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, osc_select, osc_pin_in, dark_display_input;
    logic ser_out, osc_pin_out, osc_pin_oe, refresh_tick;
    led_serial_pkg::serial_in_t ser_in;
    logic [`DOT_BITS-1:0]   led_drive;
    logic [`CWORD_BITS-1:0] cword0, cword1;
    int error_cnt = 0;
    int comparisons = 0;
    localparam logic [159:0] pat_a = {20{8'hc3}};
    localparam logic [159:0] pat_b = {20{8'h1e}};
    host_serial_model host (.core_clk(core_clk), .ser_in(ser_in));
    led_matrix_serial_load_port DUT (.core_clk(core_clk), .rst_n(rst_n), .ser_in(ser_in),
        .osc_select(osc_select), .osc_pin_in(osc_pin_in),
        .dark_display_input(dark_display_input), .ser_out(ser_out),
        .osc_pin_out(osc_pin_out), .osc_pin_oe(osc_pin_oe), .refresh_tick(refresh_tick),
        .led_drive(led_drive), .cword0(cword0), .cword1(cword1));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic end_sim;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic reset_check;
        host.step(12);
        rst_n = 1'b1;
        osc_select = 1'b1;
        host.step(2);
        `CHK(cword0, 7'h00)
        `CHK(led_drive, 160'h0)
        `CHK(osc_pin_oe, 1'b1)
    endtask : reset_check
    task automatic ctrl_check;
        host.send(1'b1, 8, 160'h82);
        `CHK(cword1, 7'h02)
        `CHK(cword0, 7'h00)
        host.send(1'b1, 8, 160'h7f);
        `CHK(cword0, 7'h7f)
        `CHK(cword1, 7'h02)
    endtask : ctrl_check
    task automatic dot_check;
        host.send(1'b0, 160, pat_a);
        `CHK(led_drive, pat_a)
        dark_display_input = 1'b1;
        host.step(2);
        `CHK(led_drive, 160'h0)
        dark_display_input = 1'b0;
        host.send(1'b0, 160, pat_b);
        `CHK(ser_out, pat_a[0])
        rst_n = 1'b0;
        host.step(2);
        rst_n = 1'b1;
        host.send(1'b1, 8, 160'h40);
        `CHK(led_drive, pat_b)
    endtask : dot_check
    // toggles the external oscillator pin every two cycles, counting refresh ticks
    task automatic count_ticks(input int n, output logic [7:0] ticks);
        ticks = 8'h00;
        for (int i = 0; i < n; i++) begin
            osc_pin_in = i[1];
            host.step(1);
            ticks = ticks + {7'h00, refresh_tick};
        end
    endtask : count_ticks
    task automatic osc_check;
        logic [7:0] ticks;
        int         waited;
        host.send(1'b1, 8, 160'h83);
        `CHK(ser_out, ser_in.data)
        osc_select = 1'b0;
        host.send(1'b1, 8, 160'h82);
        count_ticks(64, ticks);
        `CHK(ticks, 8'h02)
        host.send(1'b1, 8, 160'h80);
        count_ticks(64, ticks);
        `CHK(ticks, 8'h10)
        osc_select = 1'b1;
        waited = 0;
        while (osc_pin_out !== 1'b1 && waited < 1100) begin
            host.step(1);
            waited++;
        end
        `CHK(osc_pin_out, 1'b1)
    endtask : osc_check
    initial begin
        rst_n = 1'b0;
        osc_select = 1'b0;
        osc_pin_in = 1'b0;
        dark_display_input = 1'b0;
        reset_check();
        ctrl_check();
        dot_check();
        osc_check();
        end_sim();
    end
endmodule : testbench
